// File: hw/reference_clock_module_pkg.sv
package reference_clock_module_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [11:0] ADDR_CONTROL = 12'h895;
  localparam logic [11:0] ADDR_SOURCE  = 12'h896;

  // Control and source register layout
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_DC_LSB  = 3;
  localparam int CTRL_DIV_LSB = 0;
  localparam int SRC_LSB      = 0;

  // Reset values
  localparam logic       RST_EN  = 1'b0;
  localparam logic [1:0] RST_DC  = 2'h2;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [3:0] RST_SRC = 4'h0;

  // Duty codes
  localparam logic [1:0] DUTY_0  = 2'h0;
  localparam logic [1:0] DUTY_25 = 2'h1;
  localparam logic [1:0] DUTY_50 = 2'h2;
  localparam logic [1:0] DUTY_75 = 2'h3;

  localparam logic [2:0] DIV_NONE   = 3'h0;
  localparam logic [2:0] DIV_TWO    = 3'h1;
  localparam int         NUM_SRC    = 11;
  localparam logic [3:0] SRC_SYSTEM = 4'h0;
  localparam logic [3:0] SRC_LAST   = 4'hA;
  localparam int         SYNC_STAGES = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic       en;
    logic [1:0] duty;
    logic [2:0] div;
  } ctrl_t;

endpackage

// File: hw/reference_clock_output.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Source field 0 system, 1 high internal, 2 low internal, 3 mid 500k, 4 mid 32k, 5 secondary, 6 osc, 7-10 cells.
// RULE2: The divider field divides the selected clock by two to the power of the field value.
// RULE3: Enabling starts the output glitch free, its first pulse full width.
// RULE4: Disabling forces the output low at once.
// RULE5: Software changes divider and duty only while disabled, else glitches may occur.
// RULE6: With a nonzero divider the duty field gives 75, 50, 25 or 0 percent high time.
// RULE7: With divider zero the output is 50 percent except duty 00, which holds it low.
// RULE8: Reset loads enable 0, duty 10 and divider 000.
// RULE9: In sleep the output keeps running except when the system clock is selected.
// RULE10: Control holds enable at bit 7, duty at 4:3, divider at 2:0; bits 6:5 read zero.
// RULE11: The generated clock is also offered to other peripherals.
// RULE12: Enable and configuration are synchronised into the source domain before use.
module reference_clock_output
  import reference_clock_module_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire reference_clock_module_pkg::reg_req_t     reg_req,
  output logic [reference_clock_module_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [reference_clock_module_pkg::NUM_SRC-1:0] src_clk,
  input  wire logic                     sleep,
  output logic                          ref_clock_out_pin,
  output logic                          ref_clock_internal
);
  import reference_clock_module_pkg::*;

  // Register file, core domain
  ctrl_t                   ctrl;
  ctrl_t                   next_ctrl;
  logic [3:0]              src_sel;
  logic [3:0]              next_src_sel;
  logic [DATA_W-1:0]       next_rdata;
  logic                    wr_ctrl;
  logic                    wr_src;
  logic                    rd_ctrl;
  logic                    rd_src;

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] a);
    hit = (r.addr == a);
  endfunction

  // Last count of one output period: two to the divider power, less one
  function automatic logic [6:0] period_last(input logic [2:0] div);
    logic [7:0] span;
    span        = 8'h01 << div;
    period_last = 7'(span - 8'h01);
  endfunction

  // Whole source cycles of high time; a divide by two cannot hold a quarter
  // period, so the odd duty codes get their extra half cycle elsewhere
  function automatic logic [6:0] high_cycles(input logic [1:0] duty, input logic [6:0] last_cnt);
    logic [8:0] span;
    span = 9'(last_cnt) + 9'h01;
    case (duty)
      DUTY_75: begin
        high_cycles = 7'((span * 9'h3) >> 2);
      end
      DUTY_50: begin
        high_cycles = 7'(span >> 1);
      end
      DUTY_25: begin
        high_cycles = 7'(span >> 2);
      end
      default: begin
        high_cycles = 7'h00;
      end
    endcase
  endfunction

  // Strobe decode shared by the write and read groups
  assign wr_ctrl = reg_req.wr && hit(reg_req, ADDR_CONTROL);
  assign wr_src  = reg_req.wr && hit(reg_req, ADDR_SOURCE);
  assign rd_ctrl = reg_req.rd && hit(reg_req, ADDR_CONTROL);
  assign rd_src  = reg_req.rd && hit(reg_req, ADDR_SOURCE);

  // Control register
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.en   = reg_req.wdata[CTRL_EN_BIT];  // see RULE10
      next_ctrl.duty = reg_req.wdata[CTRL_DC_LSB +: 2];
      next_ctrl.div  = reg_req.wdata[CTRL_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl.en   <= RST_EN;  // see RULE8
      ctrl.duty <= RST_DC;
      ctrl.div  <= RST_DIV;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Source select register
  always_comb begin
    next_src_sel = src_sel;
    if (wr_src) begin
      next_src_sel = reg_req.wdata[SRC_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_sel <= RST_SRC;
    end else begin
      src_sel <= next_src_sel;
    end
  end

  // Read data stands for one cycle; unused bits and other addresses read zero
  always_comb begin
    next_rdata = '0;
    if (rd_ctrl) begin
      next_rdata[CTRL_EN_BIT]       = ctrl.en;  // see RULE10
      next_rdata[CTRL_DC_LSB +: 2]  = ctrl.duty;
      next_rdata[CTRL_DIV_LSB +: 3] = ctrl.div;
    end
    if (rd_src) begin
      next_rdata[SRC_LSB +: 4] = src_sel;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Source selection; reserved codes give no clock. The system clock is
  // taken like any other source, from input 0, not from the core clock.
  logic selected_raw;
  always_comb begin
    selected_raw = 1'b0;
    if (src_sel <= SRC_LAST) begin
      selected_raw = src_clk[src_sel];  // see RULE1
    end
  end

  // Stopping the system clock in sleep is modelled by gating input 0 here
  logic src_active;
  always_comb begin
    src_active = 1'b1;
    if (sleep && (src_sel == SRC_SYSTEM)) begin
      src_active = 1'b0;  // see RULE9
    end
  end

  // Per-source divider, shaper and output; the selected one reaches the pin.
  // Each instance's flops run on its own source clock; the final gate also uses the core-domain ctrl.en and mine.
  logic [NUM_SRC-1:0] shaped;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
      // Synchroniser and accepted configuration
      logic [SYNC_STAGES*6-1:0] sync_q;
      logic [SYNC_STAGES*6-1:0] next_sync_q;
      logic [5:0]               stage_two;
      logic [5:0]               stage_three;
      ctrl_t                    cfg;
      ctrl_t                    next_cfg;
      logic                     mine;
      logic                     en_ok;

      // Divider and shaper
      logic                     run;
      logic                     next_run;
      logic [6:0]               cnt;
      logic [6:0]               next_cnt;
      logic                     out_q;
      logic                     next_out_q;
      logic                     half_q;
      logic                     next_half_q;
      logic [6:0]               last;
      logic [6:0]               high_len;
      logic                     odd_duty;
      logic                     pass_src;
      logic                     divided;
      logic                     gated;

      assign mine        = (src_sel == 4'(g)) && src_active;
      assign en_ok       = cfg.en;
      assign stage_two   = sync_q[11:6];
      assign stage_three = sync_q[17:12];

      // Three flops; config accepted once stages two and three agree.
      // The whole word crosses together, so enable and fields never split.
      always_comb begin
        next_sync_q = {sync_q[SYNC_STAGES*6-7:0], ctrl.en & mine, ctrl.duty, ctrl.div};  // see RULE12
        next_cfg    = cfg;
        if (stage_two == stage_three) begin
          next_cfg = ctrl_t'(stage_three);
        end
      end

      always_ff @(posedge src_clk[g] or posedge rst) begin
        if (rst) begin
          sync_q   <= '0;
          cfg.en   <= RST_EN;
          cfg.duty <= RST_DC;
          cfg.div  <= RST_DIV;
        end else begin
          sync_q <= next_sync_q;
          cfg    <= next_cfg;
        end
      end

      // Period and high time follow the accepted copy, never the live register
      assign last     = period_last(cfg.div);  // see RULE2
      assign high_len = high_cycles(cfg.duty, last);  // see RULE6
      assign odd_duty = (cfg.div == DIV_TWO) && cfg.duty[0];  // see RULE6

      always_comb begin
        next_run    = en_ok;
        next_cnt    = 7'h00;
        next_out_q  = 1'b0;
        next_half_q = 1'b0;
        if (en_ok) begin
          // Start only at a counter wrap so the first pulse is full width
          if (run && (cnt < last)) begin
            next_cnt = cnt + 7'h01;
          end else begin
            next_cnt = 7'h00;  // see RULE3
          end
          if (cfg.div == DIV_NONE) begin
            next_out_q = 1'b0;  // see RULE7
          end else begin
            next_out_q = (next_cnt < high_len);  // see RULE6
          end
          if (odd_duty) begin
            next_half_q = (next_cnt == high_len);  // see RULE6
          end
        end
      end

      always_ff @(posedge src_clk[g] or posedge rst) begin
        if (rst) begin
          run    <= 1'b0;
          cnt    <= 7'h00;
          out_q  <= 1'b0;
          half_q <= 1'b0;
        end else begin
          run    <= next_run;
          cnt    <= next_cnt;
          out_q  <= next_out_q;
          half_q <= next_half_q;
        end
      end

      // Undivided case passes the source itself, gated by the accepted enable;
      // the half-cycle copy rides the source's high phase. Disable drops the
      // output at the next core clock edge, without waiting for a source edge.
      assign pass_src = run && cfg.en && (cfg.duty != DUTY_0) && src_clk[g];  // see RULE7
      assign divided  = out_q || (half_q && src_clk[g]);  // see RULE6

      always_comb begin
        gated = 1'b0;
        if (ctrl.en && mine) begin  // see RULE4
          if (cfg.div == DIV_NONE) begin
            gated = pass_src;  // see RULE7
          end else begin
            gated = divided;  // see RULE6
          end
        end
      end

      assign shaped[g] = gated;
    end
  endgenerate

  // Output flops run on the core clock with the shaped clock sampled directly;
  // a sampled pin cannot exceed half the core rate, a known limitation.
  // The internal copy has its own flop so the pin load never skews it.
  logic next_pin;
  logic next_internal;

  always_comb begin
    next_pin      = 1'b0;
    next_internal = 1'b0;
    if (ctrl.en && (src_sel <= SRC_LAST)) begin
      next_pin      = shaped[src_sel];  // see RULE4
      next_internal = shaped[src_sel];  // see RULE11
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_clock_out_pin  <= 1'b0;
      ref_clock_internal <= 1'b0;
    end else begin
      ref_clock_out_pin  <= next_pin;
      ref_clock_internal <= next_internal;
    end
  end

  logic unused_raw;
  assign unused_raw = selected_raw;

endmodule // reference_clock_output

// File: verification/reference_clock_module_props.sv
`timescale 1ns/1ps
module reference_clock_module_props
  import reference_clock_module_pkg::*;
(
  input wire logic                            core_clk,
  input wire logic                            rst,
  input wire reference_clock_module_pkg::reg_req_t            reg_req,
  input wire logic [reference_clock_module_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic                            sleep,
  input wire logic                            ref_clock_out_pin,
  input wire logic                            ref_clock_internal
);
  logic [7:0] ctrl_q;
  logic [3:0] src_q;
  // Shadow registers, masked as they read back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ctrl_q <= 8'h10;
    else if (reg_req.wr && reg_req.addr == ADDR_CONTROL) ctrl_q <= reg_req.wdata & 8'h9F;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) src_q <= 4'h0;
    else if (reg_req.wr && reg_req.addr == ADDR_SOURCE) src_q <= reg_req.wdata[3:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_off; (!ctrl_q[7])[*2]; endsequence
  sequence s_halt; (sleep && src_q == SRC_SYSTEM)[*4]; endsequence
  AST_RD_IDLE: assert property (!reg_req.rd |=> reg_rdata == 8'h00) else $error("idle read data");
  AST_RD_CTRL: assert property (reg_req.rd && reg_req.addr == ADDR_CONTROL |=> reg_rdata == ctrl_q)
    else $error("control read");
  AST_RD_SRC: assert property (reg_req.rd && reg_req.addr == ADDR_SOURCE |=> reg_rdata == {4'h0, src_q})
    else $error("source read");
  AST_MIRROR: assert property (ref_clock_internal == ref_clock_out_pin) else $error("internal copy");
  AST_OFF: assert property (s_off |-> !ref_clock_out_pin) else $error("runs while off");
  AST_DUTY_ZERO: assert property ((ctrl_q[4:3] == DUTY_0)[*4] |-> !ref_clock_out_pin)
    else $error("zero duty high");
  AST_SLEEP: assert property (s_halt |-> !ref_clock_out_pin) else $error("runs in sleep");
  // Bound assumes sources slower than the core clock by under 30 times
  AST_START: assert property ($rose(ctrl_q[7]) && ctrl_q[4:3] != DUTY_0 && ctrl_q[2:0] <= 3'h3
    && src_q <= SRC_LAST && !(sleep && src_q == SRC_SYSTEM) |-> ##[1:1000] ref_clock_out_pin) else $error("no start");
endmodule // reference_clock_module_props

bind reference_clock_output reference_clock_module_props props (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sleep(sleep), .ref_clock_out_pin(ref_clock_out_pin),
  .ref_clock_internal(ref_clock_internal));

// File: verification/src_clock_model.sv
`timescale 1ns/1ps
module src_clock_model
  import reference_clock_module_pkg::*;
(
  output logic [reference_clock_module_pkg::NUM_SRC-1:0] src_clk
);
  // Offset so source edges never meet a core edge
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    initial begin
      src_clk[i] = 1'b0;
      #7;
      forever #(40 * (4 + i)) src_clk[i] = ~src_clk[i];
    end
  end
endmodule // src_clock_model

// File: verification/reference_clock_output_bench.sv
`timescale 1ns/1ps
module reference_clock_output_bench;
  import reference_clock_module_pkg::*;
  logic               core_clk;
  logic               rst;
  logic               sleep;
  logic               pin;
  logic [7:0]         reg_rdata;
  logic [NUM_SRC-1:0] src_clk;
  reg_req_t           req;
  int                 err_count;
  int                 total_checks;

  reference_clock_output uut (.core_clk(core_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
    .src_clk(src_clk), .sleep(sleep), .ref_clock_out_pin(pin), .ref_clock_internal());
  src_clock_model sources (.src_clk(src_clk));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic r);
    @(posedge core_clk);
    req <= '{a, d, ~r, r};
    @(posedge core_clk);
    req <= '0;
    #1 if (r) chk("rdata", {8'h00, d}, {8'h00, reg_rdata});
  endtask

  // Long settle gap, so the stop reaches the slowest source domain
  task automatic run(input logic [3:0] s, input logic [1:0] d, input logic [2:0] v, input int per);
    int n;
    int h;
    int p;
    h = 0;
    p = 0;
    acc(ADDR_SOURCE, {4'h0, s}, 1'b0);
    acc(ADDR_CONTROL, {3'b100, d, v}, 1'b0);
    for (n = 0; n < 1500 && !(p > 0 && pin === 1'b1); n++) begin
      @(negedge core_clk);
      if (pin === 1'b1 && p == 0) h++;
      else if (h > 0 && pin !== 1'b1) p++;
    end
    chk("high", 16'((v == DIV_NONE) ? per / 2 : per * d / 4), 16'(h));
    chk("period", 16'(per), 16'(h + p));
    if (n == 1500 && per != 0) begin
      err_count++;
      close_out();
    end
    acc(ADDR_CONTROL, {3'b000, d, v}, 1'b0);
    repeat (2) @(negedge core_clk);
    chk("stop", 16'h0000, {15'h0000, pin});
    repeat (100) @(negedge core_clk);
  endtask

  task automatic t_regs();
    acc(ADDR_CONTROL, 8'h10, 1'b1);
    acc(ADDR_SOURCE, 8'h00, 1'b1);
    acc(ADDR_CONTROL, 8'h7F, 1'b0);
    acc(ADDR_CONTROL, 8'h1F, 1'b1);
    acc(ADDR_SOURCE, 8'hFF, 1'b0);
    acc(ADDR_SOURCE, 8'h0F, 1'b1);
    acc(12'h894, 8'h00, 1'b1);
    $display("t_regs done");
  endtask

  task automatic t_sources();
    for (int s = 0; s < 12; s++) run(4'(s), DUTY_50, 3'h1, (s < NUM_SRC) ? 4 * (4 + s) : 0);
    $display("t_sources done");
  endtask

  task automatic t_shapes();
    for (int v = 0; v < 4; v++)
      for (int d = 0; d < 4; d++) run(SRC_SYSTEM, 2'(d), 3'(v), (d == 0) ? 0 : 8 << v);
    $display("t_shapes done");
  endtask

  task automatic t_sleep();
    @(posedge core_clk);
    sleep <= 1'b1;
    run(SRC_SYSTEM, DUTY_50, 3'h1, 0);
    run(4'h3, DUTY_50, 3'h1, 28);
    sleep <= 1'b0;
    $display("t_sleep done");
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    err_count = 0;
    total_checks = 0;
    req = '0;
    sleep = 1'b0;
    rst = 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_sources();
    t_shapes();
    t_sleep();
    close_out();
  end
endmodule // reference_clock_output_bench
